// File: rtl/cis_pkg.sv
// Shared constants, opcode patterns and state encodings of the exec block.
package cis_pkg;

  // ****************************************************************
  // Widths and field positions
  // ****************************************************************
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned INSTR_W    = 14;
  localparam int unsigned BANK_W     = 5;
  localparam int unsigned LATCH_W    = 7;
  localparam int unsigned DEST_BIT   = 7;
  localparam int unsigned PSEL_MM    = 2;
  localparam int unsigned PSEL_OFS   = 6;
  localparam int unsigned OFS_FORM   = 13;
  localparam int unsigned GIE_BIT    = 7;

  // ****************************************************************
  // Indirect window addresses and reset values
  // ****************************************************************
  localparam logic [6:0]        WINDOW0_ADDR  = 7'h00;
  localparam logic [6:0]        WINDOW1_ADDR  = 7'h01;
  localparam logic [DATA_W-1:0] W_RST         = 8'h00;
  localparam logic [ADDR_W-1:0] PTR_RST       = 16'h0000;
  localparam logic [BANK_W-1:0] BANK_RST      = 5'h00;
  localparam logic [LATCH_W-1:0] LATCH_RST    = 7'h00;
  localparam logic [DATA_W-1:0] OPTION_RST    = 8'hFF;

  // ****************************************************************
  // Opcode patterns and masks
  // ****************************************************************
  localparam logic [13:0] M_ALL  = 14'h3FFF;
  localparam logic [13:0] M_MM   = 14'h3FF8;
  localparam logic [13:0] M_BANK = 14'h3FE0;
  localparam logic [13:0] M_F7   = 14'h3F80;
  localparam logic [13:0] M_F8   = 14'h3F00;
  localparam logic [13:0] P_NOP        = 14'h0000;
  localparam logic [13:0] P_SOFT_RST   = 14'h0001;
  localparam logic [13:0] P_IRQ_RET    = 14'h0009;
  localparam logic [13:0] P_OPTION     = 14'h0062;
  localparam logic [13:0] P_LOAD_MM    = 14'h0010;
  localparam logic [13:0] P_STORE_MM   = 14'h0018;
  localparam logic [13:0] P_BANK       = 14'h0020;
  localparam logic [13:0] P_ACC_STORE  = 14'h0080;
  localparam logic [13:0] P_OR_REG     = 14'h0400;
  localparam logic [13:0] P_COPY       = 14'h0800;
  localparam logic [13:0] P_INC        = 14'h0A00;
  localparam logic [13:0] P_INC_SKIP   = 14'h0F00;
  localparam logic [13:0] P_IMM_LOAD   = 14'h3000;
  localparam logic [13:0] P_LATCH      = 14'h3180;
  localparam logic [13:0] P_SHL        = 14'h3500;
  localparam logic [13:0] P_SHR        = 14'h3600;
  localparam logic [13:0] P_OR_IMM     = 14'h3800;
  localparam logic [13:0] P_LOAD_OFS   = 14'h3F00;
  localparam logic [13:0] P_STORE_OFS  = 14'h3F80;

  typedef enum logic [4:0] {
    OP_NOP, OP_SOFT_RST, OP_IRQ_RET, OP_OPTION, OP_IND_LOAD, OP_IND_STORE,
    OP_BANK, OP_ACC_STORE, OP_OR_REG, OP_COPY, OP_INC, OP_INC_SKIP,
    OP_IMM_LOAD, OP_LATCH, OP_SHL, OP_SHR, OP_OR_IMM
  } cis_op_t;

  // Gray order along fetch, execute, discard address, discard execute.
  typedef enum logic [1:0] {
    ST_FETCH   = 2'b00,
    ST_EXEC    = 2'b01,
    ST_FLUSH_A = 2'b11,
    ST_FLUSH_B = 2'b10
  } cis_state_t;

endpackage

// File: rtl/cis_ptr_unit.sv
// Effective address and pointer update for one indirect access.
`timescale 1ns/10ps
module cis_ptr_unit (
  input  wire logic [15:0] i_ptr,
  input  wire logic [1:0]  i_mode,
  input  wire logic [5:0]  i_offset,
  input  wire logic        i_offset_form,
  output logic      [15:0] o_eff_addr,
  output logic      [15:0] o_ptr_new
);
  logic [15:0] inc;
  logic [15:0] dec;
  logic [15:0] rel;

  // Plain 16-bit arithmetic wraps through zero in both directions.
  assign inc = i_ptr + 16'h0001;                              // [RQ11]
  assign dec = i_ptr - 16'h0001;                              // [RQ11]
  assign rel = i_ptr + {{10{i_offset[5]}}, i_offset};         // [RQ8]

  always_comb begin
    o_eff_addr = i_ptr;
    o_ptr_new  = i_ptr;
    if (i_offset_form) begin
      o_eff_addr = rel;                                       // [RQ9]
    end else begin
      case (i_mode)                                           // [RQ9]
        2'b00: begin
          o_eff_addr = inc;
          o_ptr_new  = inc;
        end
        2'b01: begin
          o_eff_addr = dec;
          o_ptr_new  = dec;
        end
        2'b10: begin
          o_ptr_new  = inc;
        end
        default: begin
          o_ptr_new  = dec;
        end
      endcase
    end
  end
endmodule

// File: rtl/cis_exec.sv
// Executes one slice of the 8-bit core's instruction set.
`timescale 1ns/10ps
// Behaviour
// [RQ1] Increment-and-skip routes sum by dest bit; zero skips next; no flags.
// [RQ2] OR immediate into accumulator, update zero only.
// [RQ3] Increment register, route by dest bit, update zero, never skip.
// [RQ4] OR accumulator with register, route by dest bit, zero only.
// [RQ5] Left shift: bit 7 to carry, zero into bit 0, carry and zero.
// [RQ6] Right shift: bit 0 to carry, zero into bit 7, carry and zero.
// [RQ7] Register copy to accumulator or in place, zero updated.
// [RQ8] Indirect load via pointer 0 or 1, offset -32..31, zero updated.
// [RQ9] Mode field: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// [RQ10] Window addresses redirect to location held by matching pointer.
// [RQ11] Pointers wrap modulo 16 bits.
// [RQ12] Indirect store writes accumulator, no flag changes.
// [RQ13] Bank load copies immediate into bank select, flags unchanged.
// [RQ14] Program latch load copies 7-bit immediate, flags unchanged.
// [RQ15] Immediate load into accumulator in one cycle, no flags.
// [RQ16] Accumulator store into file register in one cycle, no flags.
// [RQ17] Option load copies accumulator into option register.
// [RQ18] Soft reset requests device reset and clears its indicator.
// [RQ19] Interrupt return pops stack, sets enable bit 7, two cycles.
// [RQ20] No-op changes nothing, one word, one cycle.
// [RQ21] Skipped instruction discarded as a no-op.
// [RQ22] Other instructions take one instruction cycle.
module cis_exec (
  input  wire logic                          I_CORE_CLK,
  input  wire logic                          I_RST_N,
  input  wire logic                          I_INSTR_VALID,
  input  wire logic [cis_pkg::INSTR_W-1:0]   I_INSTR,
  input  wire logic [cis_pkg::DATA_W-1:0]    I_DATA_RDATA,
  input  wire logic [cis_pkg::DATA_W-1:0]    I_IRQ_CONTROL,
  output logic                               O_READY,
  output logic      [cis_pkg::ADDR_W-1:0]    O_DATA_ADDR,
  output logic                               O_DATA_RE,
  output logic                               O_DATA_WE,
  output logic      [cis_pkg::DATA_W-1:0]    O_DATA_WDATA,
  output logic      [cis_pkg::DATA_W-1:0]    O_W,
  output logic                               O_CARRY,
  output logic                               O_ZERO,
  output logic      [cis_pkg::ADDR_W-1:0]    O_PTR0,
  output logic      [cis_pkg::ADDR_W-1:0]    O_PTR1,
  output logic      [cis_pkg::BANK_W-1:0]    O_BANK_SELECT,
  output logic      [cis_pkg::LATCH_W-1:0]   O_UPPER_PC_LATCH,
  output logic      [cis_pkg::DATA_W-1:0]    O_OPTION,
  output logic                               O_SOFT_RESET,
  output logic                               O_SOFT_RESET_INDICATOR_N,
  output logic                               O_STACK_POP,
  output logic                               O_IRQ_CONTROL_WE,
  output logic      [cis_pkg::DATA_W-1:0]    O_IRQ_CONTROL_WDATA
);
  import cis_pkg::*;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  function automatic logic hit(input logic [13:0] ins,
                               input logic [13:0] pat,
                               input logic [13:0] msk);
    hit = ((ins & msk) == pat);
  endfunction

  function automatic cis_op_t decode(input logic [13:0] ins);
    if (hit(ins, P_NOP, M_ALL))                  decode = OP_NOP;
    else if (hit(ins, P_SOFT_RST, M_ALL))        decode = OP_SOFT_RST;
    else if (hit(ins, P_IRQ_RET, M_ALL))         decode = OP_IRQ_RET;
    else if (hit(ins, P_OPTION, M_ALL))          decode = OP_OPTION;
    else if (hit(ins, P_LOAD_MM, M_MM))          decode = OP_IND_LOAD;
    else if (hit(ins, P_STORE_MM, M_MM))         decode = OP_IND_STORE;
    else if (hit(ins, P_BANK, M_BANK))           decode = OP_BANK;
    else if (hit(ins, P_ACC_STORE, M_F7))        decode = OP_ACC_STORE;
    else if (hit(ins, P_OR_REG, M_F8))           decode = OP_OR_REG;
    else if (hit(ins, P_COPY, M_F8))             decode = OP_COPY;
    else if (hit(ins, P_INC, M_F8))              decode = OP_INC;
    else if (hit(ins, P_INC_SKIP, M_F8))         decode = OP_INC_SKIP;
    else if (hit(ins, P_IMM_LOAD, M_F8))         decode = OP_IMM_LOAD;
    else if (hit(ins, P_LATCH, M_F7))            decode = OP_LATCH;
    else if (hit(ins, P_SHL, M_F8))              decode = OP_SHL;
    else if (hit(ins, P_SHR, M_F8))              decode = OP_SHR;
    else if (hit(ins, P_OR_IMM, M_F8))           decode = OP_OR_IMM;
    else if (hit(ins, P_LOAD_OFS, M_F7))         decode = OP_IND_LOAD;
    else if (hit(ins, P_STORE_OFS, M_F7))        decode = OP_IND_STORE;
    else                                         decode = OP_NOP;
  endfunction

  cis_state_t  state_reg;
  cis_state_t  state_next;
  cis_op_t     op_in;
  cis_op_t     op_reg;
  logic [13:0] instr_reg;
  logic        take;
  logic        psel;
  logic [15:0] ptr_cur;
  logic [15:0] eff_addr;
  logic [15:0] ptr_new;
  logic [15:0] addr_next;
  logic        reads;
  logic [15:0] ptr_reg [2];
  logic [7:0]  w_reg;
  logic        carry_reg;
  logic        zero_reg;
  logic [4:0]  bank_reg;
  logic [6:0]  latch_reg;
  logic [7:0]  option_reg;
  logic        ri_n_reg;
  logic [15:0] addr_reg;
  logic        re_reg;
  logic        we_reg;
  logic [7:0]  wdata_reg;
  logic        ready_reg;
  logic        soft_rst_reg;
  logic        pop_reg;
  logic        irq_we_reg;
  logic [7:0]  irq_wdata_reg;
  logic [7:0]  res;
  logic        res_c;
  logic        to_w;
  logic        to_file;
  logic        upd_z;
  logic        upd_c;
  logic        skip;
  logic        exec;
  logic        dest;

  assign take  = (state_reg == ST_FETCH) && I_INSTR_VALID;
  assign exec  = (state_reg == ST_EXEC);
  assign op_in = decode(I_INSTR);
  assign dest  = instr_reg[DEST_BIT];
  assign psel  = I_INSTR[OFS_FORM] ? I_INSTR[PSEL_OFS] : I_INSTR[PSEL_MM];
  assign ptr_cur = ptr_reg[psel];

  cis_ptr_unit u_ptr (
    .i_ptr         (ptr_cur),
    .i_mode        (I_INSTR[1:0]),
    .i_offset      (I_INSTR[5:0]),
    .i_offset_form (I_INSTR[OFS_FORM]),
    .o_eff_addr    (eff_addr),
    .o_ptr_new     (ptr_new)
  );

  // ****************************************************************
  // Operand address
  // ****************************************************************
  always_comb begin
    reads = 1'b0;
    case (op_in)
      OP_IND_LOAD, OP_OR_REG, OP_COPY, OP_INC, OP_INC_SKIP, OP_SHL,
      OP_SHR: reads = 1'b1;
      default: reads = 1'b0;
    endcase
    if (op_in == OP_IND_LOAD || op_in == OP_IND_STORE) begin
      addr_next = eff_addr;                                   // [RQ8]
    end else if (I_INSTR[6:0] == WINDOW0_ADDR) begin
      addr_next = ptr_reg[0];                                 // [RQ10]
    end else if (I_INSTR[6:0] == WINDOW1_ADDR) begin
      addr_next = ptr_reg[1];                                 // [RQ10]
    end else begin
      addr_next = {4'h0, bank_reg, I_INSTR[6:0]};
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_FETCH:   if (take) state_next = ST_EXEC;
      ST_EXEC:    state_next = (skip || op_reg == OP_IRQ_RET) ?
                               ST_FLUSH_A : ST_FETCH;         // [RQ21]
      ST_FLUSH_A: if (I_INSTR_VALID) state_next = ST_FLUSH_B;
      default:    state_next = ST_FETCH;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= ST_FETCH;
      ready_reg <= 1'b1;
      op_reg    <= OP_NOP;
      instr_reg <= P_NOP;
      addr_reg  <= PTR_RST;
      re_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;                                // [RQ22]
      ready_reg <= (state_next == ST_FETCH) ||
                   (state_next == ST_FLUSH_A);
      re_reg    <= take && reads;
      if (take) begin
        op_reg    <= op_in;
        instr_reg <= I_INSTR;
        addr_reg  <= addr_next;
      end
    end
  end

  // ****************************************************************
  // Pointers
  // ****************************************************************
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < 2; i++) begin
        ptr_reg[i] <= PTR_RST;
      end
    end else if (take && !I_INSTR[OFS_FORM] &&
                 (op_in == OP_IND_LOAD || op_in == OP_IND_STORE)) begin
      ptr_reg[psel] <= ptr_new;                               // [RQ9]
    end
  end

  // ****************************************************************
  // Execute
  // ****************************************************************
  always_comb begin
    res     = I_DATA_RDATA;
    res_c   = carry_reg;
    to_w    = 1'b0;
    to_file = 1'b0;
    upd_z   = 1'b0;
    upd_c   = 1'b0;
    skip    = 1'b0;
    case (op_reg)
      OP_INC_SKIP: begin
        res     = I_DATA_RDATA + 8'h01;                       // [RQ1]
        to_w    = !dest;
        to_file = dest;
        skip    = (res == 8'h00);                             // [RQ1]
      end
      OP_INC: begin
        res     = I_DATA_RDATA + 8'h01;                       // [RQ3]
        to_w    = !dest;
        to_file = dest;
        upd_z   = 1'b1;
      end
      OP_OR_REG: begin
        res     = w_reg | I_DATA_RDATA;                       // [RQ4]
        to_w    = !dest;
        to_file = dest;
        upd_z   = 1'b1;
      end
      OP_SHL: begin
        res     = {I_DATA_RDATA[6:0], 1'b0};                  // [RQ5]
        res_c   = I_DATA_RDATA[7];
        to_w    = !dest;
        to_file = dest;
        upd_z   = 1'b1;
        upd_c   = 1'b1;
      end
      OP_SHR: begin
        res     = {1'b0, I_DATA_RDATA[7:1]};                  // [RQ6]
        res_c   = I_DATA_RDATA[0];
        to_w    = !dest;
        to_file = dest;
        upd_z   = 1'b1;
        upd_c   = 1'b1;
      end
      OP_COPY: begin
        to_w    = !dest;                                      // [RQ7]
        to_file = dest;
        upd_z   = 1'b1;
      end
      OP_IND_LOAD: begin
        to_w    = 1'b1;                                       // [RQ8]
        upd_z   = 1'b1;
      end
      OP_OR_IMM: begin
        res     = w_reg | instr_reg[7:0];                     // [RQ2]
        to_w    = 1'b1;
        upd_z   = 1'b1;
      end
      OP_IMM_LOAD: begin
        res     = instr_reg[7:0];                             // [RQ15]
        to_w    = 1'b1;
      end
      OP_ACC_STORE, OP_IND_STORE: begin
        res     = w_reg;                                      // [RQ12] [RQ16]
        to_file = 1'b1;
      end
      default: begin
        res     = I_DATA_RDATA;                               // [RQ20]
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      w_reg     <= W_RST;
      carry_reg <= 1'b0;
      zero_reg  <= 1'b0;
    end else if (exec) begin
      if (to_w) w_reg <= res;
      if (upd_z) zero_reg <= (res == 8'h00);
      if (upd_c) carry_reg <= res_c;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      we_reg    <= 1'b0;
      wdata_reg <= W_RST;
    end else begin
      we_reg <= exec && to_file;
      if (exec && to_file) wdata_reg <= res;
    end
  end

  // ****************************************************************
  // Configuration and control side effects
  // ****************************************************************
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bank_reg   <= BANK_RST;
      latch_reg  <= LATCH_RST;
      option_reg <= OPTION_RST;
    end else if (exec) begin
      if (op_reg == OP_BANK) bank_reg <= instr_reg[4:0];      // [RQ13]
      if (op_reg == OP_LATCH) latch_reg <= instr_reg[6:0];    // [RQ14]
      if (op_reg == OP_OPTION) option_reg <= w_reg;           // [RQ17]
    end
  end

  // Device reset sets the indicator back high, so the cause does not survive it.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ri_n_reg      <= 1'b1;
      soft_rst_reg  <= 1'b0;
      pop_reg       <= 1'b0;
      irq_we_reg    <= 1'b0;
      irq_wdata_reg <= W_RST;
    end else begin
      soft_rst_reg <= exec && (op_reg == OP_SOFT_RST);        // [RQ18]
      if (exec && op_reg == OP_SOFT_RST) ri_n_reg <= 1'b0;    // [RQ18]
      pop_reg    <= exec && (op_reg == OP_IRQ_RET);           // [RQ19]
      irq_we_reg <= exec && (op_reg == OP_IRQ_RET);
      if (exec && op_reg == OP_IRQ_RET) begin
        irq_wdata_reg <= I_IRQ_CONTROL | 8'(1 << GIE_BIT);    // [RQ19]
      end
    end
  end

  assign O_READY                  = ready_reg;
  assign O_DATA_ADDR              = addr_reg;
  assign O_DATA_RE                = re_reg;
  assign O_DATA_WE                = we_reg;
  assign O_DATA_WDATA             = wdata_reg;
  assign O_W                      = w_reg;
  assign O_CARRY                  = carry_reg;
  assign O_ZERO                   = zero_reg;
  assign O_PTR0                   = ptr_reg[0];
  assign O_PTR1                   = ptr_reg[1];
  assign O_BANK_SELECT            = bank_reg;
  assign O_UPPER_PC_LATCH         = latch_reg;
  assign O_OPTION                 = option_reg;
  assign O_SOFT_RESET             = soft_rst_reg;
  assign O_SOFT_RESET_INDICATOR_N = ri_n_reg;
  assign O_STACK_POP              = pop_reg;
  assign O_IRQ_CONTROL_WE         = irq_we_reg;
  assign O_IRQ_CONTROL_WDATA      = irq_wdata_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_discard;
    (state_reg == ST_FLUSH_A) ##1 (state_reg inside {ST_FLUSH_A,
                                                      ST_FLUSH_B});
  endsequence
  property p_skip;
    exec && op_reg == OP_INC_SKIP && I_DATA_RDATA == 8'hFF |=> s_discard;
  endproperty
  a_skip: assert property (p_skip) else $error("skip lost"); // [RQ1]
  property p_skip_flags;
    exec && op_reg == OP_INC_SKIP |=> $stable(zero_reg) && $stable(carry_reg);
  endproperty
  a_skip_flags: assert property (p_skip_flags) else $error("flags"); // [RQ1]
  property p_or_imm;
    exec && op_reg == OP_OR_IMM |=>
      w_reg == ($past(w_reg) | $past(instr_reg[7:0])) &&
      zero_reg == (w_reg == 8'h00);
  endproperty
  a_or_imm: assert property (p_or_imm) else $error("or imm bad"); // [RQ2]
  property p_inc;
    exec && op_reg == OP_INC && !dest |=>
      w_reg == 8'($past(I_DATA_RDATA) + 8'h01) && state_reg == ST_FETCH;
  endproperty
  a_inc: assert property (p_inc) else $error("inc bad"); // [RQ3]
  property p_shl;
    exec && op_reg == OP_SHL |=> carry_reg == $past(I_DATA_RDATA[7]);
  endproperty
  a_shl: assert property (p_shl) else $error("shl carry"); // [RQ5]
  property p_shr;
    exec && op_reg == OP_SHR && !dest |=>
      carry_reg == $past(I_DATA_RDATA[0]) && !w_reg[7];
  endproperty
  a_shr: assert property (p_shr) else $error("shr bad"); // [RQ6]
  property p_wrap;
    take && op_in == OP_IND_LOAD && I_INSTR == 14'h0012 &&
      ptr_reg[0] == 16'hFFFF |=> ptr_reg[0] == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap"); // [RQ11]
  property p_store;
    exec && op_reg == OP_IND_STORE |=>
      O_DATA_WE && O_DATA_WDATA == w_reg && $stable(zero_reg);
  endproperty
  a_store: assert property (p_store) else $error("store bad"); // [RQ12]
  property p_ret;
    exec && op_reg == OP_IRQ_RET |=>
      O_STACK_POP && O_IRQ_CONTROL_WDATA[7] && O_READY ##0 s_discard;
  endproperty
  a_ret: assert property (p_ret) else $error("return bad"); // [RQ19]
endmodule

// File: verification/cpu_instruction_subset_exec_tb_top.sv
// Self-checking bench for the instruction slice executor.
`timescale 1ns/10ps
module cpu_instruction_subset_exec_tb_top;
  import cis_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, vld = 1'b0;
  logic [13:0] ins = 14'h0000;
  logic [7:0]  rd = 8'h00, irq = 8'h00;
  logic        rdy, re, we, srst, srst_n, pop, irqwe, c, z;
  logic [15:0] addr, p0, p1;
  logic [7:0]  wd, w, opt, irqwd;
  logic [4:0]  bank;
  logic [6:0]  lat;
  int          n_errors = 0, compares = 0, cyc = 0, seed = 77;
  // Reference state of the executor.
  logic [7:0]  mw, mopt;
  logic        mc, mz, mskip, mind;
  logic [15:0] mp [2];
  logic [4:0]  mbank;
  logic [6:0]  mlat;
  logic [21:0] corner [22] = '{{P_IMM_LOAD | 14'h004F, 8'h00},
    {P_OPTION, 8'h00}, {P_LOAD_MM | 14'h0001, 8'h00},
    {P_LOAD_MM | 14'h0002, 8'h80}, {P_STORE_OFS | 14'h0060, 8'h00},
    {P_COPY, 8'h00}, {P_ACC_STORE | 14'h0001, 8'h00},
    {P_SHL | 14'h0020, 8'h80}, {P_SHR | 14'h00A0, 8'h01},
    {P_INC_SKIP | 14'h0030, 8'hFF}, {P_IMM_LOAD | 14'h0055, 8'h00},
    {P_INC_SKIP | 14'h00B0, 8'hFF}, {P_NOP, 8'h00},
    {P_INC_SKIP | 14'h0030, 8'h10}, {P_IRQ_RET, 8'h00},
    {P_OR_IMM | 14'h00FF, 8'h00}, {P_BANK | 14'h000F, 8'h00},
    {P_LATCH | 14'h007F, 8'h00}, {P_INC | 14'h0085, 8'hFF},
    {P_OR_REG | 14'h0005, 8'hF0}, {P_STORE_MM | 14'h0007, 8'h00},
    {P_NOP, 8'h00}};
  logic [13:0] pat [18] = '{P_INC_SKIP, P_OR_IMM, P_INC, P_OR_REG, P_SHL,
    P_SHR, P_COPY, P_LOAD_MM, P_STORE_MM, P_LOAD_OFS, P_STORE_OFS, P_BANK,
    P_LATCH, P_IMM_LOAD, P_ACC_STORE, P_OPTION, P_NOP, P_IRQ_RET};
  logic [13:0] opm [18] = '{14'hFF, 14'hFF, 14'hFF, 14'hFF, 14'hFF, 14'hFF,
    14'hFF, 14'h07, 14'h07, 14'h7F, 14'h7F, 14'h0F, 14'h7F, 14'hFF, 14'h7F,
    14'h00, 14'h00, 14'h00};

  always #4 clk = ~clk;

  cis_exec dut_u (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_INSTR_VALID(vld), .I_INSTR(ins),
    .I_DATA_RDATA(rd), .I_IRQ_CONTROL(irq), .O_READY(rdy),
    .O_DATA_ADDR(addr), .O_DATA_RE(re), .O_DATA_WE(we), .O_DATA_WDATA(wd),
    .O_W(w), .O_CARRY(c), .O_ZERO(z), .O_PTR0(p0), .O_PTR1(p1),
    .O_BANK_SELECT(bank), .O_UPPER_PC_LATCH(lat), .O_OPTION(opt),
    .O_SOFT_RESET(srst), .O_SOFT_RESET_INDICATOR_N(srst_n),
    .O_STACK_POP(pop), .O_IRQ_CONTROL_WE(irqwe),
    .O_IRQ_CONTROL_WDATA(irqwd)
  );

  // ****************************************************************
  // Comparison and closing
  // ****************************************************************
  task automatic check(input string nm, input logic [63:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp_state();
    check("w_flags", 64'({w, c, z}), 64'({mw, mc, mz}));
    check("pointers", 64'({p0, p1}), 64'({mp[0], mp[1]}));
    check("config", 64'({bank, lat, opt, srst_n}),
          64'({mbank, mlat, mopt, mind}));
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    {mw, mc, mz, mskip, mind, mopt} = {W_RST, 4'b0001, OPTION_RST};
    {mp[0], mp[1], mbank, mlat} = {PTR_RST, PTR_RST, BANK_RST, LATCH_RST};
    @(negedge clk);
    cmp_state();
    check("pulses", 64'({rdy, we, srst, pop, irqwe}), 64'h10);
  endtask

  // ****************************************************************
  // One instruction: reference update, issue, compare
  // ****************************************************************
  task automatic run(input logic [13:0] i, input logic [7:0] r);
    logic [15:0] ea, pn, pn1;
    logic [7:0]  res, nw;
    logic        sel, rdq, wrq, dst, zu, sr, pp, drop;
    drop = mskip;
    {mskip, rdq, wrq, dst, zu, sr, pp, res, nw} = {7'h00, r, mw};
    sel = (i[13:8] == 6'h3F) ? i[6] : i[2];
    pn = mp[sel];
    pn1 = i[0] ? pn - 16'h0001 : pn + 16'h0001;
    ea = (i[6:0] == WINDOW0_ADDR) ? mp[0] :
         (i[6:0] == WINDOW1_ADDR) ? mp[1] : {4'h0, mbank, i[6:0]};
    case (1'b1)
      drop: ;
      (i & M_F8) == P_INC_SKIP: {rdq, dst, res, mskip} =
                                {2'b11, r + 8'h01, r == 8'hFF};
      (i & M_F8) == P_OR_IMM: {zu, res, nw} = {1'b1, mw | i[7:0], mw | i[7:0]};
      (i & M_F8) == P_INC: {rdq, dst, zu, res} = {3'b111, r + 8'h01};
      (i & M_F8) == P_OR_REG: {rdq, dst, zu, res} = {3'b111, mw | r};
      (i & M_F8) == P_SHL: {rdq, dst, zu, mc, res} = {3'b111, r, 1'b0};
      (i & M_F8) == P_SHR: {rdq, dst, zu, res, mc} = {3'b111, 1'b0, r};
      (i & M_F8) == P_COPY: {rdq, dst, zu} = 3'b111;
      (i & M_F8) == P_LOAD_OFS: begin
        ea = pn + {{10{i[5]}}, i[5:0]};
        {rdq, zu, wrq, res, nw} = i[7] ? {3'b001, mw, mw} : {3'b110, r, r};
      end
      (i & M_MM) == P_LOAD_MM, (i & M_MM) == P_STORE_MM: begin
        {ea, mp[sel]} = {i[1] ? pn : pn1, pn1};
        {rdq, zu, wrq, res, nw} = i[3] ? {3'b001, mw, mw} : {3'b110, r, r};
      end
      (i & M_BANK) == P_BANK: mbank = i[4:0];
      (i & M_F7) == P_LATCH: mlat = i[6:0];
      (i & M_F8) == P_IMM_LOAD: nw = i[7:0];
      (i & M_F7) == P_ACC_STORE: {wrq, res} = {1'b1, mw};
      i == P_OPTION: mopt = mw;
      i == P_SOFT_RST: {sr, mind} = 2'b10;
      i == P_IRQ_RET: {pp, mskip} = 2'b11;
      default: ;
    endcase
    if (dst)
      {wrq, nw} = i[7] ? {1'b1, mw} : {1'b0, res};
    if (zu)
      mz = (res == 8'h00);
    mw = nw;
    @(posedge clk);
    {ins, vld, irq} <= {i, 1'b1, 8'($random(seed))};
    @(posedge clk);
    {vld, rd} <= {1'b0, r};
    @(negedge clk);
    check("exec", 64'({rdy, re}), 64'({1'b0, rdq}));
    if (rdq || wrq)
      check("addr", 64'(addr), 64'(ea));
    @(negedge clk);
    cmp_state();
    check("pulses", 64'({rdy, we, srst, pop, irqwe}),
          64'({1'b1, wrq, sr, pp, pp}));
    if (wrq)
      check("wdata", 64'(wd), 64'(res));
    if (pp)
      check("irq_wdata", 64'(irqwd), 64'(irq | 8'h80));
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    int j;
    do_reset();
    foreach (corner[k])
      run(corner[k][21:8], corner[k][7:0]);
    for (int k = 0; k < 300; k++) begin
      j = int'($unsigned($random(seed)) % 18);
      run(pat[j] | (14'($random(seed)) & opm[j]),
          ($random(seed) & 3) == 0 ? 8'hFF : 8'($random(seed)));
    end
    run(P_NOP, 8'h00);
    run(P_SOFT_RST, 8'h00);
    do_reset();
    conclude();
  end
endmodule
